/* rtl/pfs_pkg.sv */
// Package for the power supply fault supervisor.
// Assumes a 50 MHz system clock and a 32-bit Avalon-MM register bus.
package pfs_pkg;

  // Clock and timing base.
  localparam int CLK_HZ          = 50000000;
  localparam int TICK_US         = 1;
  localparam int TICK_CYCLES     = CLK_HZ / 1000000 * TICK_US;
  localparam int TICK_W          = 6;

  // Printed times, each in its own unit.
  localparam int PG_DELAY_MS     = 250;
  localparam int OFF_DELAY_US    = 2500;
  localparam int RETRY_DELAY_S   = 1;
  localparam int BLANK_MS        = 64;

  // The same times in microsecond ticks.
  localparam int PG_DELAY_TICKS  = PG_DELAY_MS * 1000 / TICK_US;
  localparam int OFF_DELAY_TICKS = OFF_DELAY_US / TICK_US;
  localparam int RETRY_TICKS     = RETRY_DELAY_S * 1000000 / TICK_US;
  localparam int BLANK_TICKS     = BLANK_MS * 1000 / TICK_US;
  localparam int TIMER_W         = 24;

  // Input filter length in clock cycles.
  localparam int DEB_CYCLES      = 16;
  localparam int DEB_W           = 5;

  // Filtered inputs, one bit per monitor.
  localparam int NUM_MON         = 12;
  localparam int MON_AUX_OV      = 0;
  localparam int MON_AUX_UV      = 1;
  localparam int MON_MAIN_OV     = 2;
  localparam int MON_MAIN_UV     = 3;
  localparam int MON_NEG_OV      = 4;
  localparam int MON_NEG_UV      = 5;
  localparam int MON_NEG_OFF     = 6;
  localparam int MON_SUPPLY_OV   = 7;
  localparam int MON_LOCKOUT     = 8;
  localparam int MON_GND_OPEN    = 9;
  localparam int MON_MAINS_OK    = 10;
  localparam int MON_PROGRAM_SELECT_SEL    = 11;

  // Programming word.
  localparam int PROGRAM_SELECT_W          = 32;
  localparam int OPT_LATCH_MODE  = 0;
  localparam int OPT_HYST_EN     = 1;

  // Register map, byte addresses.
  localparam logic [3:0] REG_STATUS  = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  localparam logic [3:0] REG_PROGRAM_SELECT    = 4'h8;
  localparam logic [1:0] CONTROL_RST = 2'h0;
  localparam int CTL_FORCE_OFF   = 0;
  localparam int CTL_LATCH_MODE  = 1;

  // Comparator results as they arrive from the analog front end.
  typedef struct packed {
    logic progSelect;
    logic mainsOk;
    logic groundOpen;
    logic supplyLockout;
    logic supplyOv;
    logic negDisable;
    logic negUv;
    logic negOv;
    logic mainUv;
    logic mainOv;
    logic auxUv;
    logic auxOv;
  } pfs_mon_t;

  // Latched faults, also the low bits of the status register.
  typedef struct packed {
    logic uvBounce;
    logic uvLatch;
    logic mainOvLatch;
    logic supplyOvLatch;
    logic auxUvLatch;
    logic auxOvLatch;
  } pfs_fault_t;

  typedef enum logic [1:0] {UV_IDLE, UV_LATCHED, UV_RETRY} pfs_uv_t;

endpackage

/* rtl/pfs_debounce.sv */
// Input filter for one asynchronous level.
// Assumes the raw level may change at any time relative to clk.
`timescale 1ns/100ps
`default_nettype none
module pfs_debounce
  import pfs_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic resetn,
  // Raw level and filtered result.
  input  wire logic rawIn,
  output var  logic filtered
);

  logic             syncA;
  logic             syncB;
  logic             syncC;
  logic [DEB_W-1:0] stableCount;

  // The new level counts only while the second and third stages agree.
  wire agree    = (syncB == syncC);
  wire differs  = agree && (syncC != filtered);
  wire countEnd = (stableCount == DEB_W'(DEB_CYCLES - 1));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= rawIn;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // A level must hold for the full count before it is accepted.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stableCount <= '0;
      filtered    <= 1'b0;
    end else if (!differs) begin
      stableCount <= '0;
    end else if (countEnd) begin
      stableCount <= '0;
      filtered    <= syncC;
    end else begin
      stableCount <= stableCount + DEB_W'(1);
    end
  end

endmodule
`default_nettype wire

/* rtl/pfs_supervisor.sv */
// Fault supervision and sequencing of a secondary-side supply housekeeper.
// Assumes comparator results arrive as asynchronous levels and software
// reaches the registers over Avalon-MM with waitrequest.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int PG_TICKS    = PG_DELAY_TICKS,
  parameter int OFF_TICKS   = OFF_DELAY_TICKS,
  parameter int RETRY_COUNT = RETRY_TICKS,
  parameter int BLANK_COUNT = BLANK_TICKS
)
(
  // Clock and reset.
  input  wire logic                clk,
  input  wire logic                resetn,
  // Comparator results.
  input  wire pfs_mon_t            monitors,
  // Supply-on request pin, serial clock in programming mode.
  input  wire logic                supplyOnRequest,
  // Power good pin, open drain, serial data in programming mode.
  input  wire logic                powerGoodIn,
  output var  logic                powerGoodOut,
  output var  logic                powerGoodOe,
  // Converter controls.
  output var  logic                mainOffRequest,
  output var  logic                auxFaultDrive,
  output var  logic                auxLoopPullLow,
  output var  logic                mainsHystSinkEn,
  output var  logic [PROGRAM_SELECT_W-1:0]   programWord,
  // Avalon-MM slave.
  input  wire logic [3:0]          avsAddress,
  input  wire logic                avsRead,
  input  wire logic                avsWrite,
  input  wire logic [31:0]         avsWritedata,
  input  wire logic [3:0]          avsByteenable,
  output var  logic [31:0]         avsReaddata,
  output var  logic                avsWaitrequest
);

  logic [NUM_MON-1:0] rawMon;
  logic [NUM_MON-1:0] mon;
  logic               supplyOnFilt;

  // Every comparator result passes its own filter.
  assign rawMon = monitors;
  for (genvar i = 0; i < NUM_MON; i++) begin : g_filter
    pfs_debounce u_filter (
      .clk      (clk),
      .resetn   (resetn),
      .rawIn    (rawMon[i]),
      .filtered (mon[i])
    );
  end

  pfs_debounce u_supply_on (
    .clk      (clk),
    .resetn   (resetn),
    .rawIn    (supplyOnRequest),
    .filtered (supplyOnFilt)
  );

  wire lockout  = mon[MON_LOCKOUT];
  wire progMode = mon[MON_PROGRAM_SELECT_SEL];
  // Mains low is a brownout.
  wire mainsOk  = mon[MON_MAINS_OK];
  // Negative rail comparators count only while the pin is not pulled up.
  wire negOn    = !mon[MON_NEG_OFF];
  wire mainOv   = mon[MON_MAIN_OV] || (negOn && mon[MON_NEG_OV]);
  wire mainUv   = mon[MON_MAIN_UV] || (negOn && mon[MON_NEG_UV]);

  // Serial programming port, three-stage synchronisers.
  logic       clkS1;
  logic       clkS2;
  logic       clkS3;
  logic       serClk;
  logic       datS1;
  logic       datS2;
  logic       datS3;
  logic       serDat;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      clkS1 <= 1'b0;
      clkS2 <= 1'b0;
      clkS3 <= 1'b0;
      datS1 <= 1'b0;
      datS2 <= 1'b0;
      datS3 <= 1'b0;
    end else begin
      clkS1 <= supplyOnRequest;
      clkS2 <= clkS1;
      clkS3 <= clkS2;
      datS1 <= powerGoodIn;
      datS2 <= datS1;
      datS3 <= datS2;
    end
  end

  wire clkAgree = (clkS2 == clkS3);
  wire datAgree = (datS2 == datS3);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      serClk <= 1'b0;
      serDat <= 1'b0;
    end else begin
      if (clkAgree)
        serClk <= clkS3;
      if (datAgree)
        serDat <= datS3;
    end
  end

  wire serRise = progMode && clkAgree && clkS3 && !serClk;

  // Volatile programming memory, shifted in MSB first.
  always_ff @(posedge clk) begin
    if (!resetn || lockout) begin
      programWord <= '0;
    end else if (serRise) begin
      programWord <= {programWord[PROGRAM_SELECT_W-2:0], serDat};
    end
  end

  // Software control register.
  logic [1:0] control;
  wire latchMode = programWord[OPT_LATCH_MODE] || control[CTL_LATCH_MODE];
  wire hystEn    = programWord[OPT_HYST_EN];

  // The pin is a clock in programming mode, so the request keeps its
  // last normal-mode value rather than toggling with the serial clock.
  logic onReq;
  logic onReqSeen;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      onReq <= 1'b0;
    end else if (!progMode) begin
      onReq <= supplyOnFilt;
    end
  end

  // A supply-on cycle is a high followed by a return to low.
  wire onCycled = onReqSeen && !onReq;
  always_ff @(posedge clk) begin
    if (!resetn || lockout)
      onReqSeen <= 1'b0;
    else
      onReqSeen <= onReq;
  end

  // Microsecond tick divider.
  logic [TICK_W-1:0] tickDiv;
  wire tick = (tickDiv == TICK_W'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!resetn || tick)
      tickDiv <= '0;
    else
      tickDiv <= tickDiv + TICK_W'(1);
  end

  // Blanking windows.
  logic [TIMER_W-1:0] auxBlankCnt;
  logic [TIMER_W-1:0] mainBlankCnt;
  logic               uvRestart;
  wire auxBlankDone  = (auxBlankCnt == TIMER_W'(BLANK_COUNT));
  wire mainBlankDone = (mainBlankCnt == TIMER_W'(BLANK_COUNT));
  wire mainEnabled   = mainsOk && !onReq;

  // Aux window runs from valid supply.
  always_ff @(posedge clk) begin
    if (!resetn || lockout)
      auxBlankCnt <= '0;
    else if (tick && !auxBlankDone)
      auxBlankCnt <= auxBlankCnt + TIMER_W'(1);
  end

  // Main window runs from valid mains with the converter enabled.
  always_ff @(posedge clk) begin
    if (!resetn || lockout || !mainEnabled || uvRestart)
      mainBlankCnt <= '0;
    else if (tick && !mainBlankDone)
      mainBlankCnt <= mainBlankCnt + TIMER_W'(1);
  end

  // Fault latches; a set in the clearing cycle wins.
  pfs_fault_t fault;
  logic       auxOvLatch;
  logic       auxUvLatch;
  logic       supplyOvLatch;
  logic       mainOvLatch;
  wire setAuxOv = mon[MON_AUX_OV];
  wire setAuxUv = mon[MON_AUX_UV] && auxBlankDone;
  wire setSupOv = mon[MON_SUPPLY_OV];
  wire mainUvEv = mainUv && mainBlankDone && mainsOk;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      auxOvLatch    <= 1'b0;
      auxUvLatch    <= 1'b0;
      supplyOvLatch <= 1'b0;
    end else begin
      auxOvLatch    <= setAuxOv || (auxOvLatch && !lockout);
      auxUvLatch    <= setAuxUv || (auxUvLatch && !lockout);
      supplyOvLatch <= setSupOv || (supplyOvLatch && !lockout);
    end
  end

  // Main overvoltage has no blanking.
  always_ff @(posedge clk) begin
    if (!resetn)
      mainOvLatch <= 1'b0;
    else
      mainOvLatch <= mainOv || (mainOvLatch && !lockout && !onCycled);
  end

  // Main undervoltage: latch or bounce restart.
  pfs_uv_t            uvState;
  logic [TIMER_W-1:0] retryCnt;
  wire retryDone = (retryCnt == TIMER_W'(RETRY_COUNT));
  wire uvClear   = lockout || onCycled;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      uvState   <= UV_IDLE;
      retryCnt  <= '0;
      uvRestart <= 1'b0;
    end else begin
      uvRestart <= 1'b0;
      unique case (uvState)
        UV_IDLE: begin
          retryCnt <= '0;
          if (mainUvEv)
            uvState <= latchMode ? UV_LATCHED : UV_RETRY;
        end
        UV_LATCHED: begin
          if (uvClear)
            uvState <= UV_IDLE;
        end
        UV_RETRY: begin
          if (uvClear) begin
            uvState <= UV_IDLE;
          end else if (retryDone) begin
            uvState   <= UV_IDLE;
            uvRestart <= 1'b1;
          end else if (tick) begin
            retryCnt <= retryCnt + TIMER_W'(1);
          end
        end
      endcase
    end
  end

  // One driver for the whole fault word keeps the status bits coherent.
  assign fault = {uvState == UV_RETRY, uvState == UV_LATCHED, mainOvLatch,
                  supplyOvLatch, auxUvLatch, auxOvLatch};

  // Turn-off delay after a recognised supply-on request.
  logic [TIMER_W-1:0] offCnt;
  wire offDone = (offCnt == TIMER_W'(OFF_TICKS));
  always_ff @(posedge clk) begin
    if (!resetn || !onReq)
      offCnt <= '0;
    else if (tick && !offDone)
      offCnt <= offCnt + TIMER_W'(1);
  end

  // Power good delay once every rail is above its limit.
  wire anyFault = (|fault) || mon[MON_GND_OPEN];
  wire allGood  = !mainUv && !mon[MON_AUX_UV] && mainsOk && !anyFault &&
                  !onReq && !lockout && mainBlankDone;
  logic [TIMER_W-1:0] pgCnt;
  wire pgDone = (pgCnt == TIMER_W'(PG_TICKS));
  always_ff @(posedge clk) begin
    if (!resetn || !allGood)
      pgCnt <= '0;
    else if (tick && !pgDone)
      pgCnt <= pgCnt + TIMER_W'(1);
  end

  // Output decode.
  wire next_mainOff  = lockout || (onReq && offDone) || anyFault ||
                       control[CTL_FORCE_OFF];
  wire next_auxFault = !lockout && (fault.auxOvLatch ||
                       fault.supplyOvLatch ||
                       mon[MON_GND_OPEN]);
  wire next_loopLow  = !lockout && fault.auxUvLatch;
  wire next_pg       = allGood && pgDone && !progMode;
  wire next_hyst     = !lockout && hystEn && !mainsOk;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mainOffRequest  <= 1'b1;
      auxFaultDrive   <= 1'b0;
      auxLoopPullLow  <= 1'b0;
      powerGoodOut    <= 1'b0;
      powerGoodOe     <= 1'b1;
      mainsHystSinkEn <= 1'b0;
    end else begin
      mainOffRequest  <= next_mainOff;
      auxFaultDrive   <= next_auxFault;
      auxLoopPullLow  <= next_loopLow;
      powerGoodOut    <= 1'b0;
      // Open drain: the pin is pulled low unless power is good, and is
      // released entirely in programming mode to act as data input.
      powerGoodOe     <= !next_pg && !progMode;
      mainsHystSinkEn <= next_hyst;
    end
  end

  // Avalon-MM slave with one wait cycle per access.
  wire        request  = avsRead || avsWrite;
  wire        accept   = request && !avsWaitrequest;
  wire        hitCtl   = (avsAddress == REG_CONTROL);
  wire [31:0] statusWord = {16'h0, 1'b0, uvState == UV_IDLE, progMode,
                            mainsOk, onReq, lockout, mainOffRequest,
                            powerGoodOe, 2'h0, fault};
  wire [31:0] readMux  = (avsAddress == REG_STATUS)  ? statusWord :
                         hitCtl                      ? {30'h0, control} :
                         (avsAddress == REG_PROGRAM_SELECT)    ? programWord :
                                                       32'h0;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h0;
    end else if (request && avsWaitrequest) begin
      avsWaitrequest <= 1'b0;
      avsReaddata    <= avsRead ? readMux : 32'h0;
    end else begin
      avsWaitrequest <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn)
      control <= CONTROL_RST;
    else if (accept && avsWrite && hitCtl && avsByteenable[0])
      control <= avsWritedata[1:0];
  end

endmodule
`default_nettype wire

/* sim/pfs_supervisor_assertions.sv */
// Concurrent checks on the fault supervisor's top-level ports.
// Assumes it is bound to every supervisor instance in the bench.
`timescale 1ns/100ps
`default_nettype none
module pfs_supervisor_checker
  import pfs_pkg::*;
#(
  parameter int OFF_TICKS = 5
)
(
  // Clock and reset.
  input wire logic              clk,
  input wire logic              resetn,
  // Inputs.
  input wire pfs_mon_t          monitors,
  input wire logic              supplyOnRequest,
  input wire logic              avsRead,
  input wire logic              avsWrite,
  // Outputs.
  input wire logic              powerGoodOe,
  input wire logic              mainOffRequest,
  input wire logic              auxFaultDrive,
  input wire logic [PROGRAM_SELECT_W-1:0] programWord,
  input wire logic              avsWaitrequest
);
  // The filters settle within about 22 cycles, so 32 stable cycles suffice.
  localparam int OFFC = OFF_TICKS * TICK_CYCLES + 60;
  wire logic onReq;
  wire logic gnd;
  wire logic lock;
  assign onReq = supplyOnRequest && !monitors.progSelect;
  assign gnd = monitors.groundOpen;
  assign lock = monitors.supplyLockout;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_bus_one_wait: assert property (
    (avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus answer not after one wait cycle");
  a_wait_pulse: assert property (!avsWaitrequest |=> avsWaitrequest)
    else $error("wait request low for more than one cycle");
  a_wait_cause: assert property (
    $fell(avsWaitrequest) |-> $past(avsRead) || $past(avsWrite))
    else $error("bus answer without a request");
  a_pg_drop: assert property (
    onReq[*8] ##1 onReq[*8] ##1 onReq[*8] ##1 onReq[*8] |-> powerGoodOe)
    else $error("power good kept during turn-off request");
  a_off_delay: assert property (
    onReq[*8] ##1 onReq[*8] ##1 onReq[*8] ##1 onReq[*8]
    |-> ##[0:OFFC] mainOffRequest)
    else $error("main off not raised after the off delay");
  a_pg_good: assert property (
    $fell(powerGoodOe) && !monitors.progSelect
    |-> !mainOffRequest && !auxFaultDrive)
    else $error("power good released while a converter is off");
  a_gnd_forces: assert property (
    gnd[*8] ##1 gnd[*8] ##1 gnd[*8] ##1 gnd[*8]
    |-> mainOffRequest && auxFaultDrive)
    else $error("open ground did not force both outputs");
  a_lockout_off: assert property (
    lock[*8] ##1 lock[*8] ##1 lock[*8] ##1 lock[*8]
    |-> mainOffRequest && powerGoodOe && programWord == '0)
    else $error("lockout did not force the off state");
endmodule

bind pfs_supervisor pfs_supervisor_checker #(.OFF_TICKS(OFF_TICKS))
  u_pfs_supervisor_checker (
    .clk(clk), .resetn(resetn), .monitors(monitors),
    .supplyOnRequest(supplyOnRequest), .avsRead(avsRead),
    .avsWrite(avsWrite), .powerGoodOe(powerGoodOe),
    .mainOffRequest(mainOffRequest), .auxFaultDrive(auxFaultDrive),
    .programWord(programWord), .avsWaitrequest(avsWaitrequest));
`default_nettype wire

/* sim/pfs_program_select_tester.sv */
// Programming tester model that shifts one word over the serial pins.
// Assumes the bench resolves the open-drain data pin with a pull-up.
`timescale 1ns/100ps
`default_nettype none
module pfs_program_select_tester
  import pfs_pkg::*;
(
  // Clock.
  input  wire logic              clk,
  // Frame request.
  input  wire logic              start,
  input  wire logic [PROGRAM_SELECT_W-1:0] word,
  output var  logic              busy,
  // Serial pins.
  output var  logic              serClk,
  output var  logic              serData,
  output var  logic              dataOe
);
  // The clock stands low between frames; data is held five cycles
  // around each rising edge so the synchroniser cannot miss it.
  initial begin
    busy = 1'b0;
    serClk = 1'b0;
    serData = 1'b0;
    dataOe = 1'b0;
    forever begin
      @(posedge clk);
      if (start) begin
        busy <= 1'b1;
        dataOe <= 1'b1;
        for (int i = PROGRAM_SELECT_W - 1; i >= 0; i--) begin
          serData <= word[i];
          repeat (5) @(posedge clk);
          serClk <= 1'b1;
          repeat (5) @(posedge clk);
          serClk <= 1'b0;
        end
        repeat (5) @(posedge clk);
        dataOe <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* sim/psu_fault_supervisor_test.sv */
// Self-checking bench for the power supply fault supervisor.
// Assumes the bound checker and the programming tester model.
`timescale 1ns/100ps
`default_nettype none
module psu_fault_supervisor_test;
  import pfs_pkg::*;
  localparam int PGT = 20;
  localparam int OFT = 5;
  localparam int PGC = (PGT - 1) * TICK_CYCLES;
  localparam logic [31:0] WORD = 32'ha5c3_0f12;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  pfs_mon_t    mon = 12'h400;
  logic        req = 1'b0;
  logic        start = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'hf;
  int          errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  wire logic   sClk, sDat, sOe, busy, onPin, pgIn, pgOe, mainOff;
  wire logic   auxFault, loopLow, hyst, waitReq, pgOut;
  wire logic [31:0] word, rdata;
  // Power good is open drain with a pull-up; the tester drives data.
  assign pgIn = pgOe ? 1'b0 : (sOe ? sDat : 1'b1);
  assign onPin = req | sClk;
  pfs_supervisor #(.PG_TICKS(PGT), .OFF_TICKS(OFT), .RETRY_COUNT(10),
    .BLANK_COUNT(8)) u_pfs_supervisor (.clk(clk), .resetn(resetn),
    .monitors(mon), .supplyOnRequest(onPin), .powerGoodIn(pgIn),
    .powerGoodOut(pgOut), .powerGoodOe(pgOe), .mainOffRequest(mainOff),
    .auxFaultDrive(auxFault), .auxLoopPullLow(loopLow),
    .mainsHystSinkEn(hyst), .programWord(word), .avsAddress(adr),
    .avsRead(rd), .avsWrite(wr), .avsWritedata(wdat),
    .avsByteenable(be), .avsReaddata(rdata), .avsWaitrequest(waitReq));
  pfs_program_select_tester u_pfs_program_select_tester (.clk(clk), .start(start),
    .word(WORD), .busy(busy), .serClk(sClk), .serData(sDat),
    .dataOe(sOe));
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      test_done;
    end
  end
  task automatic test_done;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    be <= b;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitReq !== 1'b0);
    q = rdata;
    chk("answerWait", 32'h2, n);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic waitOut(input logic sel, input logic v, input int lim,
                         output int n);
    n = 0;
    while ((sel ? mainOff : pgOe) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic lockout;
    int n;
    mon.supplyLockout <= 1'b1;
    tick(40);
    chk("lockMain", 1'b1, mainOff);
    chk("lockGood", 1'b1, pgOe);
    chk("lockAux", 1'b0, auxFault);
    chk("lockWord", 32'h0, word);
    chk("lockPin", 1'b0, pgOut);
    mon.supplyLockout <= 1'b0;
    waitOut(1'b0, 1'b0, 4000, n);
    chk("pgDelay", 1'b1, n >= PGC);
    chk("pgMain", 1'b0, mainOff);
  endtask
  task automatic t_regs;
    logic [31:0] q;
    int n;
    bus(1'b0, REG_CONTROL, 32'h0, 4'hf, q);
    chk("ctlReset", {30'h0, CONTROL_RST}, q);
    bus(1'b1, REG_CONTROL, 32'h1, 4'h0, q);
    bus(1'b0, REG_CONTROL, 32'h0, 4'hf, q);
    chk("ctlByteEnable", 32'h0, q);
    bus(1'b1, REG_CONTROL, 32'h1, 4'hf, q);
    tick(4);
    chk("forceOff", 1'b1, mainOff);
    bus(1'b1, REG_STATUS, 32'h0, 4'hf, q);
    bus(1'b0, REG_STATUS, 32'h0, 4'hf, q);
    chk("statusOff", 1'b1, q[9]);
    bus(1'b1, REG_CONTROL, 32'h0, 4'hf, q);
    bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf, q);
    bus(1'b0, 4'hc, 32'h0, 4'hf, q);
    chk("unmapped", 32'h0, q);
    waitOut(1'b0, 1'b0, 4000, n);
    $display("register test done");
  endtask
  task automatic t_supply_on;
    int n;
    req <= 1'b1;
    waitOut(1'b0, 1'b1, 100, n);
    chk("pgDrop", 1'b1, n <= 30);
    waitOut(1'b1, 1'b1, 600, n);
    chk("offDelay", 1'b1, n >= (OFT - 1) * TICK_CYCLES &&
        n <= OFT * TICK_CYCLES + 5);
    req <= 1'b0;
    waitOut(1'b1, 1'b0, 100, n);
    chk("onAgain", 1'b0, mainOff);
    waitOut(1'b0, 1'b0, 4000, n);
    $display("supply-on test done");
  endtask
  task automatic t_program;
    logic [31:0] q;
    int n;
    mon.progSelect <= 1'b1;
    tick(40);
    chk("progRelease", 1'b0, pgOe);
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(2);
    n = 0;
    while (busy && n < 1000) begin
      tick(1);
      n++;
    end
    chk("progWord", WORD, word);
    bus(1'b0, REG_PROGRAM_SELECT, 32'h0, 4'hf, q);
    chk("progRead", WORD, q);
    mon.progSelect <= 1'b0;
    tick(40);
    $display("programming test done");
  endtask
  task automatic t_mains;
    int n;
    mon.mainsOk <= 1'b0;
    mon.mainUv <= 1'b1;
    tick(40);
    chk("brownMain", 1'b0, mainOff);
    chk("hystOn", 1'b1, hyst);
    mon.mainUv <= 1'b0;
    mon.mainsOk <= 1'b1;
    tick(40);
    chk("hystOff", 1'b0, hyst);
    waitOut(1'b0, 1'b0, 4000, n);
    mon.negDisable <= 1'b1;
    mon.negOv <= 1'b1;
    tick(40);
    chk("negOff", 1'b0, mainOff);
    mon.negDisable <= 1'b0;
    tick(40);
    chk("negOn", 1'b1, mainOff);
    mon.negOv <= 1'b0;
    lockout;
    $display("mains and negative rail test done");
  endtask
  task automatic t_fault(input int i, input logic aux, input logic loop,
                         input logic held, input logic cyc);
    mon[i] <= 1'b1;
    tick(40);
    chk("faultMain", 1'b1, mainOff);
    chk("faultAux", aux, auxFault);
    chk("faultLoop", loop, loopLow);
    mon[i] <= 1'b0;
    tick(40);
    chk("faultHeld", held, mainOff);
    if (cyc) begin
      req <= 1'b1;
      tick(40);
      req <= 1'b0;
      tick(40);
      chk("faultCycle", 1'b0, mainOff);
    end
    lockout;
    $display("fault test %0d done", i);
  endtask
  task automatic t_main_uv(input logic latch);
    logic [31:0] q;
    bus(1'b1, REG_CONTROL, {30'h0, latch, 1'b0}, 4'hf, q);
    mon.mainUv <= 1'b1;
    tick(40);
    chk("uvMain", 1'b1, mainOff);
    mon.mainUv <= 1'b0;
    tick(800);
    chk("uvRetry", latch, mainOff);
    bus(1'b1, REG_CONTROL, 32'h0, 4'hf, q);
    lockout;
    $display("main undervoltage test %0d done", latch);
  endtask
  initial begin
    int n;
    tick(20);
    resetn <= 1'b1;
    tick(1);
    waitOut(1'b0, 1'b0, 4000, n);
    chk("pgFirst", 1'b1, n >= PGC);
    t_regs;
    t_supply_on;
    t_program;
    t_mains;
    t_fault(MON_AUX_OV, 1'b1, 1'b0, 1'b1, 1'b0);
    t_fault(MON_AUX_UV, 1'b0, 1'b1, 1'b1, 1'b0);
    t_fault(MON_SUPPLY_OV, 1'b1, 1'b0, 1'b1, 1'b0);
    t_fault(MON_MAIN_OV, 1'b0, 1'b0, 1'b1, 1'b1);
    t_fault(MON_GND_OPEN, 1'b1, 1'b0, 1'b0, 1'b0);
    t_main_uv(1'b0);
    t_main_uv(1'b1);
    test_done;
  end
endmodule
`default_nettype wire
